// *** core/ufeam_pkg.sv ***
// Package: map, fields and timing of the serial receiver with address match
package ufeam_pkg;
    //==================================================================
    // Bus geometry
    localparam int ADDR_W = 12;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    //==================================================================
    // Register indices; byte address is four times the index
    localparam logic [9:0] SCTRL_IDX = 10'h010;
    localparam logic [9:0] PCTRL_IDX = 10'h011;
    localparam logic [9:0] SERIAL_BUFFER_IDX = 10'h012;
    localparam logic [9:0] BAUD_IDX = 10'h013;
    localparam logic [9:0] IRQ_ST_IDX = 10'h014;
    localparam logic [9:0] IRQ_MSK_IDX = 10'h015;
    localparam logic [9:0] SLAVE_ADDRESS_IDX = 10'h0a9;
    localparam logic [9:0] SMASK_IDX = 10'h0b9;
    localparam logic [ADDR_W-1:0] SCTRL_ADDR = {SCTRL_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] PCTRL_ADDR = {PCTRL_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] SERIAL_BUFFER_ADDR = {SERIAL_BUFFER_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] BAUD_ADDR = {BAUD_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] IRQ_ST_ADDR = {IRQ_ST_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] IRQ_MSK_ADDR = {IRQ_MSK_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] SLAVE_ADDRESS_ADDR = {SLAVE_ADDRESS_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] SMASK_ADDR = {SMASK_IDX, 2'b00};
    //==================================================================
    // Field positions
    localparam int SC_MODE_HI = 7;
    localparam int SC_MODE_LO = 6;
    localparam int SC_MPEN = 5;
    localparam int SC_RXEN = 4;
    localparam int SC_TB8 = 3;
    localparam int SC_RB8 = 2;
    localparam int SC_RI = 0;
    localparam int PC_FESEL = 6;
    localparam int IRQ_RI = 0;
    localparam int IRQ_FE = 1;
    //==================================================================
    // Reset values and mode codes
    localparam logic [7:0] SLAVE_ADDRESS_RST = 8'h00;
    localparam logic [7:0] SMASK_RST = 8'h00;
    localparam logic [1:0] IRQ_MSK_RST = 2'h0;
    localparam logic [1:0] MODE1 = 2'h1;
    //==================================================================
    // Timing: 16 slices per bit, votes on slices 7, 8 and 9
    localparam int CLK_HZ = 50_000_000;
    localparam int BAUD_RST = 9600;
    localparam int BAUD_DIV_RST = CLK_HZ / (BAUD_RST * 16) - 1;
    localparam logic [3:0] SLICE_FIRST = 4'h7;
    localparam logic [3:0] SLICE_LAST = 4'h9;
endpackage: ufeam_pkg

// *** core/ufeam_addr_match.sv ***
// Given and broadcast address comparator
`timescale 1ns/1ns
`default_nettype none
module ufeam_addr_match
#(
    parameter int W = 8
)
(
    input wire logic [W-1:0] rx_byte,
    input wire logic [W-1:0] slave_address,
    input wire logic [W-1:0] mask,
    output logic hit
);
    logic [W-1:0] bcast;
    logic given_hit;
    logic bcast_hit;
    //==================================================================
    // Compare
    // Mask zeros are don't care; all-zero registers match everything
    assign given_hit = ((rx_byte ^ slave_address) & mask) == '0;
    assign bcast = slave_address | mask;
    assign bcast_hit = (rx_byte & bcast) == bcast;
    assign hit = given_hit || bcast_hit;
endmodule: ufeam_addr_match
`default_nettype wire

// *** core/ufeam_rx_shift.sv ***
// Oversampling frame receiver with majority vote per bit
`timescale 1ns/1ns
`default_nettype none
module ufeam_rx_shift
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic rx_line,
    input wire logic tick,
    input wire logic enable,
    input wire logic nine_bits,
    output logic done,
    output logic [7:0] rx_byte,
    output logic rx_ninth,
    output logic stop_ok
);
    import ufeam_pkg::*;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ufeam_rx_state_type;
    ufeam_rx_state_type state_reg;
    logic [3:0] slice_reg;
    logic [3:0] bit_reg;
    logic [1:0] pair_reg;
    logic [8:0] shift_reg;
    logic line_prev_reg;
    logic done_reg;
    logic stop_reg;
    logic vote;
    logic [3:0] last_bit;
    //==================================================================
    // Two of three vote: slices 7 and 8 held, slice 9 live
    assign vote = (pair_reg[1] & pair_reg[0]) | (rx_line & (pair_reg[1] | pair_reg[0]));
    assign last_bit = nine_bits ? 4'h8 : 4'h7;
    assign done = done_reg;
    assign stop_ok = stop_reg;
    assign rx_byte = nine_bits ? shift_reg[7:0] : shift_reg[8:1];
    assign rx_ninth = nine_bits & shift_reg[8];
    //==================================================================
    // Edge history for start detection
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            line_prev_reg <= 1'b1;
        else
            line_prev_reg <= rx_line;
    end
    //==================================================================
    // Frame sequencer; falling edge realigns the slice counter
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_reg <= RX_IDLE;
            slice_reg <= 4'h0;
            bit_reg <= 4'h0;
            pair_reg <= 2'h3;
            shift_reg <= 9'h000;
            done_reg <= 1'b0;
            stop_reg <= 1'b0;
        end
        else
        begin
            done_reg <= 1'b0;
            if (state_reg == RX_IDLE)
            begin
                slice_reg <= 4'h0;
                bit_reg <= 4'h0;
                if (enable && line_prev_reg && !rx_line)
                    state_reg <= RX_START;
            end
            else if (tick)
            begin
                slice_reg <= slice_reg + 4'h1;
                if (slice_reg >= SLICE_FIRST && slice_reg < SLICE_LAST)
                    pair_reg <= {pair_reg[0], rx_line};
                if (slice_reg == SLICE_LAST)
                begin
                    unique case (state_reg)
                        RX_START: state_reg <= vote ? RX_IDLE : RX_DATA;
                        RX_DATA:
                        begin
                            // LSB first; ninth bit ends up on top
                            shift_reg <= {vote, shift_reg[8:1]};
                            bit_reg <= bit_reg + 4'h1;
                            if (bit_reg == last_bit)
                                state_reg <= RX_STOP;
                        end
                        RX_STOP:
                        begin
                            // Extra shift done; hand the frame over mid stop bit
                            done_reg <= 1'b1;
                            stop_reg <= vote;
                            state_reg <= RX_IDLE;
                        end
                        RX_IDLE: state_reg <= RX_IDLE;
                    endcase
                end
            end
        end
    end
    //==================================================================
    // Checks
    stop_vote_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_reg == RX_STOP && tick && slice_reg == SLICE_LAST) |=> (done && stop_ok == $past(vote)))
        else $error("stop bit not taken from vote");
    start_abort_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_reg == RX_START && tick && slice_reg == SLICE_LAST && vote) |=> state_reg == RX_IDLE)
        else $error("bad start bit not aborted");
    done_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
        done |=> !done)
        else $error("frame done longer than one cycle");
endmodule: ufeam_rx_shift
`default_nettype wire

// *** core/ufeam_top.sv ***
// Top: AXI4-Lite serial receiver with frame error flag and address match
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
//======================================================================
// Function
// - Missing stop bit sets frame error flag
// - Control bit 7 shows error or mode
// - Mode bit and error flag stored apart
// - Error flag sticky until software clears
// - Ninth bit high marks address frames
// - Modes 2/3 multiproc: ninth bit, address match
// - Multiproc off: every frame completes unless the buffer is full
// - Mode 1 multiproc: stop and match
// - Mask picks compared slave address bits
// - Broadcast is address OR mask
// - Address and mask reset to zero
// - Modes 2/3 store received ninth bit
// - Load and flag after extra shift
module ufeam_top
#(
    parameter int DIV_W = 16
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    output logic awready,
    input wire logic [ufeam_pkg::ADDR_W-1:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [ufeam_pkg::ADDR_W-1:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    input wire logic rx_pin,
    output logic irq
);
    import ufeam_pkg::*;
    if (DIV_W < 4 || DIV_W > 32)
    begin : g_bad_div
        $error("DIV_W must be 4 to 32");
    end
    //==================================================================
    // Declarations
    logic aw_rdy_reg, w_rdy_reg, bvalid_reg, ar_rdy_reg, rvalid_reg, wlane_reg, wr_go, wr_ok, rd_go, rd_ok;
    logic sc_wr, pc_wr, sm0_reg, fe_reg, sm1_reg, mpen_reg, rxen_reg, tb8_reg, rb8_reg, ri_reg, fesel_reg;
    logic tick_reg, irq_reg, rx_meta_reg, rx_sync_reg, sc_bit7, rx_done, rx_ninth, rx_stop, addr_hit;
    logic tag_bit, accept, fe_event;
    logic [1:0] bresp_reg, rresp_reg, irq_st_reg, irq_msk_reg, mode;
    logic [31:0] rdata_reg, rd_val;
    logic [ADDR_W-1:0] waddr_reg;
    logic [7:0] wbyte_reg, slave_address_reg, smask_reg, serial_buffer_reg, rx_byte;
    logic [23:0] wdata_hi_reg;
    logic [DIV_W-1:0] div_reg, cnt_reg;
    assign awready = aw_rdy_reg;
    assign wready = w_rdy_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign arready = ar_rdy_reg;
    assign rvalid = rvalid_reg;
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;
    assign irq = irq_reg;
    //==================================================================
    // Write channel: address and data taken in either order
    // A channel is full exactly while its ready is low
    assign wr_go = !aw_rdy_reg && !w_rdy_reg && !bvalid_reg;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_rdy_reg <= 1'b1;
            w_rdy_reg <= 1'b1;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            waddr_reg <= '0;
            wbyte_reg <= 8'h00;
            wlane_reg <= 1'b0;
        end
        else
        begin
            if (awvalid && aw_rdy_reg)
            begin
                aw_rdy_reg <= 1'b0;
                waddr_reg <= awaddr;
            end
            if (wvalid && w_rdy_reg)
            begin
                w_rdy_reg <= 1'b0;
                wbyte_reg <= wdata[7:0];
                wlane_reg <= wstrb[0];
            end
            if (wr_go)
            begin
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid_reg && bready)
            begin
                // Both channels reopen only after the response is gone
                bvalid_reg <= 1'b0;
                aw_rdy_reg <= 1'b1;
                w_rdy_reg <= 1'b1;
            end
        end
    end
    // Write decode; lane 0 carries every writable register but the baud divisor, which takes the whole word; buffer and status ignore writes
    assign wr_ok = waddr_reg inside {SCTRL_ADDR, PCTRL_ADDR, SERIAL_BUFFER_ADDR, BAUD_ADDR,
        IRQ_ST_ADDR, IRQ_MSK_ADDR, SLAVE_ADDRESS_ADDR, SMASK_ADDR};
    assign sc_wr = wr_go && wlane_reg && waddr_reg == SCTRL_ADDR;
    assign pc_wr = wr_go && wlane_reg && waddr_reg == PCTRL_ADDR;
    //==================================================================
    // Read channel: one-cycle answer from a registered mux
    assign rd_go = arvalid && ar_rdy_reg;
    assign sc_bit7 = fesel_reg ? fe_reg : sm0_reg;
    always_comb
    begin
        rd_ok = 1'b1;
        unique case (araddr)
            SCTRL_ADDR: rd_val = {24'h00_0000, sc_bit7, sm1_reg, mpen_reg, rxen_reg, tb8_reg, rb8_reg, 1'b0, ri_reg};
            PCTRL_ADDR: rd_val = {25'h000_0000, fesel_reg, 6'h00};
            SERIAL_BUFFER_ADDR: rd_val = {24'h00_0000, serial_buffer_reg};
            BAUD_ADDR: rd_val = 32'(div_reg);
            IRQ_ST_ADDR: rd_val = {30'h0000_0000, irq_st_reg};
            IRQ_MSK_ADDR: rd_val = {30'h0000_0000, irq_msk_reg};
            SLAVE_ADDRESS_ADDR: rd_val = {24'h00_0000, slave_address_reg};
            SMASK_ADDR: rd_val = {24'h00_0000, smask_reg};
            default:
            begin
                rd_val = 32'h0000_0000;
                rd_ok = 1'b0;
            end
        endcase
    end
    // Read answer held until rready; address refused meanwhile
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ar_rdy_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= RESP_OKAY;
        end
        else if (rd_go)
        begin
            ar_rdy_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_val;
            rresp_reg <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end
        else if (rvalid_reg && rready)
        begin
            rvalid_reg <= 1'b0;
            ar_rdy_reg <= 1'b1;
        end
    end
    //==================================================================
    // Pin synchroniser; only the second stage is read
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rx_meta_reg <= 1'b1;
            rx_sync_reg <= 1'b1;
        end
        else
        begin
            rx_meta_reg <= rx_pin;
            rx_sync_reg <= rx_meta_reg;
        end
    end
    // Sixteen-times baud tick
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt_reg <= '0;
            tick_reg <= 1'b0;
        end
        else
        begin
            tick_reg <= cnt_reg >= div_reg;
            cnt_reg <= (cnt_reg >= div_reg) ? '0 : cnt_reg + DIV_W'(1);
        end
    end
    //==================================================================
    // Receiver and address comparator
    assign mode = {sm0_reg, sm1_reg};
    ufeam_rx_shift u_rx
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .rx_line(rx_sync_reg),
        .tick(tick_reg),
        .enable(rxen_reg && mode != 2'h0),
        .nine_bits(mode[1]),
        .done(rx_done),
        .rx_byte(rx_byte),
        .rx_ninth(rx_ninth),
        .stop_ok(rx_stop)
    );
    ufeam_addr_match #(.W(8)) u_match
    (
        .rx_byte(rx_byte),
        .slave_address(slave_address_reg),
        .mask(smask_reg),
        .hit(addr_hit)
    );
    // Address marker: stop bit in mode 1, ninth bit in modes 2/3
    assign tag_bit = (mode == MODE1) ? rx_stop : rx_ninth;
    // A full buffer drops the frame instead of overwriting it
    assign accept = rx_done && !ri_reg && (!mpen_reg || (tag_bit && addr_hit));
    assign fe_event = rx_done && !rx_stop;
    //==================================================================
    // Serial control: mode high bit and error flag are separate flops
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sm0_reg <= 1'b0;
            sm1_reg <= 1'b0;
            mpen_reg <= 1'b0;
            rxen_reg <= 1'b0;
            tb8_reg <= 1'b0;
        end
        else if (sc_wr)
        begin
            if (!fesel_reg)
                sm0_reg <= wbyte_reg[SC_MODE_HI];
            sm1_reg <= wbyte_reg[SC_MODE_LO];
            mpen_reg <= wbyte_reg[SC_MPEN];
            rxen_reg <= wbyte_reg[SC_RXEN];
            tb8_reg <= wbyte_reg[SC_TB8];
        end
    end
    // Error flag; hardware set wins over a software write
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            fe_reg <= 1'b0;
        else if (fe_event)
            fe_reg <= 1'b1;
        else if (sc_wr && fesel_reg)
            fe_reg <= wbyte_reg[SC_MODE_HI];
    end
    // Completion flag and received ninth bit, or stop bit in mode 1
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ri_reg <= 1'b0;
            rb8_reg <= 1'b0;
            serial_buffer_reg <= 8'h00;
        end
        else
        begin
            if (accept)
            begin
                ri_reg <= 1'b1;
                rb8_reg <= tag_bit;
                serial_buffer_reg <= rx_byte;
            end
            else if (sc_wr)
            begin
                ri_reg <= wbyte_reg[SC_RI];
                rb8_reg <= wbyte_reg[SC_RB8];
            end
        end
    end
    //==================================================================
    // Power control select, address, mask and baud divisor
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            fesel_reg <= 1'b0;
            slave_address_reg <= SLAVE_ADDRESS_RST;
            smask_reg <= SMASK_RST;
            div_reg <= DIV_W'(BAUD_DIV_RST);
        end
        else
        begin
            if (pc_wr)
                fesel_reg <= wbyte_reg[PC_FESEL];
            if (wr_go && wlane_reg && waddr_reg == SLAVE_ADDRESS_ADDR)
                slave_address_reg <= wbyte_reg;
            if (wr_go && wlane_reg && waddr_reg == SMASK_ADDR)
                smask_reg <= wbyte_reg;
            if (wr_go && waddr_reg == BAUD_ADDR)
                div_reg <= DIV_W'({wdata_hi_reg, wbyte_reg});
        end
    end
    // Baud word kept from the full data beat
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            wdata_hi_reg <= 24'h00_0000;
        else if (wvalid && w_rdy_reg)
            wdata_hi_reg <= wdata[31:8];
    end
    //==================================================================
    // Interrupts: sticky events, cleared by reading, set wins
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_st_reg <= 2'h0;
            irq_msk_reg <= IRQ_MSK_RST;
            irq_reg <= 1'b0;
        end
        else
        begin
            irq_st_reg <= ((rd_go && araddr == IRQ_ST_ADDR) ? 2'h0 : irq_st_reg)
                | {fe_event, accept};
            if (wr_go && wlane_reg && waddr_reg == IRQ_MSK_ADDR)
                irq_msk_reg <= wbyte_reg[1:0];
            irq_reg <= |(irq_st_reg & irq_msk_reg);
        end
    end
    //==================================================================
    // Checks
    fe_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (rx_done && !rx_stop) |=> fe_reg)
        else $error("frame error not flagged");
    fe_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (fe_reg && !(sc_wr && fesel_reg)) |=> fe_reg)
        else $error("frame error flag lost");
    bit7_view_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (rd_go && araddr == SCTRL_ADDR) |=> rdata[SC_MODE_HI] == $past(sc_bit7))
        else $error("control bit 7 shows wrong flag");
    mode_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (sc_wr && fesel_reg) |=> sm0_reg == $past(sm0_reg))
        else $error("mode bit changed by error access");
    mp_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (rx_done && mpen_reg && mode[1] && !rx_ninth && !sc_wr) |=> ri_reg == $past(ri_reg))
        else $error("data frame completed under multiproc");
    all_frames_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (rx_done && !mpen_reg && !ri_reg) |=> (ri_reg && serial_buffer_reg == $past(rx_byte)))
        else $error("frame not completed with multiproc off");
    mode1_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (rx_done && mpen_reg && mode == MODE1 && !rx_stop && !sc_wr) |=> ri_reg == $past(ri_reg))
        else $error("mode 1 bad stop completed");
    ninth_store_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (accept && mode[1]) |=> rb8_reg == $past(rx_ninth))
        else $error("ninth bit not stored");
    full_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (ri_reg && rx_done && !sc_wr) |=> serial_buffer_reg == $past(serial_buffer_reg))
        else $error("buffer overwritten while flag set");
    addr_reset_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(aresetn) |-> (slave_address_reg == SLAVE_ADDRESS_RST && smask_reg == SMASK_RST && addr_hit))
        else $error("address registers not cleared");
endmodule: ufeam_top
`default_nettype wire

// *** sim/ufeam_serial_peer.sv ***
// Peer node model that drives frames onto the receive line
`timescale 1ns/1ns
`default_nettype none
module ufeam_serial_peer
#(
    parameter int BIT_NS = 320
)
(
    output logic line
);
    // Line idles high, as a pulled-up wire would
    initial line = 1'b1;
    // One frame: start, data LSB first, stop
    task automatic send(input logic [8:0] d, input logic nine, input logic stop);
        int i;
        #1; // Off the clock edge, so the pin never races the sampler
        line = 1'b0;
        #(BIT_NS);
        for (i = 0; i < (nine ? 9 : 8); i++)
        begin
            line = d[i];
            #(BIT_NS);
        end
        line = stop;
        #(BIT_NS);
        line = 1'b1;
    endtask: send
endmodule: ufeam_serial_peer
`default_nettype wire

// *** sim/ufeam_bench.sv ***
// Bench: random frames checked against an address-match model
`timescale 1ns/1ns
`default_nettype none
module uart_frame_error_and_address_match_bench;
    import ufeam_pkg::*;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, rx_pin, irq, mp, st, nn, acc, fe, g, bc;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d, rv;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r, mode, msk;
    logic [8:0] b;
    logic [7:0] bufx;
    int n_errors = 0;
    int checked = 0;
    int seed = 78;
    int i;
    ufeam_top ufeam_top_i (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
        .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .rx_pin, .irq);
    ufeam_serial_peer ufeam_serial_peer_i (.line(rx_pin));
    // 50 MHz clock
    initial
    begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    //==================================================================
    // Checks and verdict
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e)
        begin
            n_errors++;
            $display("[FAIL] %s exp %h seen %h", nm, e, s);
        end
    endtask: chk
    task automatic end_sim();
        if (n_errors == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask: end_sim
    // A spent wait bound ends the run
    task automatic tmo(input int n);
        if (n == 50)
        begin
            n_errors++;
            end_sim();
        end
    endtask: tmo
    //==================================================================
    // Bus cycles; ready lines stay high so no answer is missed
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] v);
        int n;
        awaddr <= a;
        wdata <= {24'h00_0000, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
            if (bvalid)
                break;
        end
        tmo(n);
        chk("bresp", bresp, RESP_OKAY);
    endtask: wr
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] v, output logic [1:0] e);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (arready)
                arvalid <= 1'b0;
            if (rvalid)
                break;
        end
        tmo(n);
        v = rdata;
        e = rresp;
    endtask: rd
    //==================================================================
    // Main sequence
    initial
    begin
        {aresetn, awvalid, wvalid, arvalid, awaddr, araddr, wdata} = '0;
        {wstrb, bready, rready} = 6'h3f;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(SLAVE_ADDRESS_ADDR, d, r);
        chk("slave_address", d, 32'h0000_0000);
        rd(SMASK_ADDR, d, r);
        chk("smask", d, 32'h0000_0000);
        rd(12'hffc, d, r);
        chk("unmapped", r, RESP_SLVERR);
        wr(BAUD_ADDR, 8'h00);
        wr(SLAVE_ADDRESS_ADDR, 8'ha4);
        wr(SMASK_ADDR, 8'hfa);
        fe = 1'b0;
        bufx = 8'h00;
        for (i = 0; i < 24; i++)
        begin
            mode = 2'(i % 3 + 1);
            rv = $random(seed);
            {msk, st, mp, b} = {rv[13:12], rv[11:10] != 2'h0, rv[9:0]};
            if (i % 4 == 0)
                b[7:0] = 8'ha0 | (b[7:0] & 8'h05);
            if (i % 4 == 1)
                b[7:1] = 7'h7f;
            wr(SCTRL_ADDR, {mode, mp, 5'h10});
            wr(IRQ_MSK_ADDR, {6'h00, msk});
            ufeam_serial_peer_i.send(b, mode != MODE1, st);
            repeat (4) @(posedge aclk);
            // Given match on masked bits, broadcast on ones of address OR mask
            g = ((b[7:0] ^ 8'ha4) & 8'hfa) == 8'h00;
            bc = (b[7:0] & 8'hfe) == 8'hfe;
            nn = (mode == MODE1) ? st : b[8];
            acc = !mp || (nn && (g || bc));
            fe = fe | !st;
            bufx = acc ? b[7:0] : bufx;
            chk("irq", irq, |({!st, acc} & msk));
            rd(IRQ_ST_ADDR, d, r);
            chk("status", d, {30'h0, !st, acc});
            rd(SCTRL_ADDR, d, r);
            chk("ctrl", d, {24'h0, mode, mp, 2'h2, acc & nn, 1'b0, acc});
            chk("irq clear", irq, 32'h0);
            rd(SERIAL_BUFFER_ADDR, d, r);
            chk("buffer", d, {24'h0, bufx});
            wr(PCTRL_ADDR, 8'h40);
            rd(SCTRL_ADDR, d, r);
            chk("error flag", d[7], fe);
            wr(PCTRL_ADDR, 8'h00);
        end
        // Mode 0 must not take frames from this line
        wr(SCTRL_ADDR, 8'h10);
        ufeam_serial_peer_i.send(9'h0a5, 1'b0, 1'b1);
        repeat (4) @(posedge aclk);
        rd(IRQ_ST_ADDR, d, r);
        chk("mode 0 idle", d, 32'h0000_0000);
        wr(SCTRL_ADDR, 8'h80);
        wr(PCTRL_ADDR, 8'h40);
        wr(SCTRL_ADDR, 8'h00);
        rd(SCTRL_ADDR, d, r);
        chk("error clear", d[7], 32'h0);
        wr(PCTRL_ADDR, 8'h00);
        rd(SCTRL_ADDR, d, r);
        chk("mode kept", d[7], 32'h1);
        end_sim();
    end
endmodule: uart_frame_error_and_address_match_bench
`default_nettype wire
